// ### core/tpe_edge_filter.sv
`default_nettype none

module tpe_edge_filter (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sample_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       run_in,
  output logic            edge_out
);

  // ----------------------------------------------------------------
  // two-sample level filter
  // ----------------------------------------------------------------
  logic level_reg;
  logic seen_reg;
  logic armed_reg;
  logic edge_reg;
  logic change;
  logic edge_ok;

  assign change = sample_in && (pin_in != level_reg);

  // prohibited code never yields an edge
  always_comb begin
    case (tpe_pkg::tpe_edge_t'(mode_in))
      tpe_pkg::EDGE_FALL: edge_ok = !pin_in;
      tpe_pkg::EDGE_RISE: edge_ok = pin_in;
      tpe_pkg::EDGE_BOTH: edge_ok = 1'b1;
      default:            edge_ok = 1'b0;
    endcase
  end

  // armed after the first run since reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_reg <= 1'b0;
    end else if (run_in) begin
      armed_reg <= 1'b1;
    end
  end

  // held low until first run: a high pin then shows as a rising edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_reg <= 1'b0;
      seen_reg  <= 1'b0;
    end else if (run_in || armed_reg) begin // R11 R12
      if (change && seen_reg) begin // R15
        level_reg <= pin_in;
        seen_reg  <= 1'b0;
      end else if (change) begin
        seen_reg <= 1'b1;
      end else if (sample_in) begin
        seen_reg <= 1'b0;
      end
    end
  end

  // tracking goes on while stopped, so restart finds the true level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= run_in && change && seen_reg && edge_ok; // R2 R3 R6 R12
    end
  end

  assign edge_out = edge_reg;

endmodule

`default_nettype wire

// ### core/tpe_top.sv
`default_nettype none

// Function
// R1: reset clears all four prescaler and edge registers of both timers to zero.
// R2: timer 0 bits 7:6 pick the second-input edge: 00 fall, 01 rise, 11 both, 10 none.
// R3: timer 0 bits 5:4 pick the first-input edge with the same coding.
// R4: timer 0 select 0..6 gives fxx/2, /16, watch tick, first-input edge, /4, /64, /256.
// R5: timer 1 select 0..6 gives fxx/2, /4, /16, first-input edge, /32, /128, /256.
// R6: timer 1 bits 7:6 and 5:4 pick second and first input edges with the same coding.
// R7: select bits 1:0 come from the first register and bit 2 from bit 0 of the second.
// R8: an external count pulse must last longer than two fxx/2 periods.
// R9: software must not use the first-input edge as count clock and as clear or capture.
// R10: software stops the timer before writing its prescaler registers.
// R11: first run after reset with rise or both and a high pin sees a rising edge.
// R12: run after a stop sees no false rising edge from an already high pin.
// R13: in interval mode a compare match clears the counter to zero and counting goes on.
// R14: in interval mode the compare interrupt pulses with every clear on match.
// R15: inputs are sampled at the count clock and an edge needs the new level twice.
// R16: the counter adds one per count tick while running and wraps past all ones.
// R17: unused register bits read as zero and writes to them are dropped.

module tpe_top #(
  parameter int CNT_W = 16
) (
  input  wire logic             CLK_SYS_IN,
  input  wire logic             NRST_IN,
  input  wire logic [31:0]      REG_ADDR_IN,
  input  wire logic             REG_WR_IN,
  input  wire logic             REG_RD_IN,
  input  wire logic [7:0]       REG_WDATA_IN,
  output logic      [7:0]       REG_RDATA_OUT,
  input  wire logic             T0_RUN_IN,
  input  wire logic             T1_RUN_IN,
  input  wire logic             T0_INTERVAL_IN,
  input  wire logic             T1_INTERVAL_IN,
  input  wire logic [CNT_W-1:0] T0_COMPARE_IN,
  input  wire logic [CNT_W-1:0] T1_COMPARE_IN,
  input  wire logic             WATCH_TIMER_IRQ_IN,
  input  wire logic             T0_FIRST_INPUT_PIN_IN,
  input  wire logic             T0_SECOND_INPUT_PIN_IN,
  input  wire logic             T1_FIRST_INPUT_PIN_IN,
  input  wire logic             T1_SECOND_INPUT_PIN_IN,
  output logic      [CNT_W-1:0] T0_COUNT_OUT,
  output logic      [CNT_W-1:0] T1_COUNT_OUT,
  output logic                  T0_COMPARE_IRQ_OUT,
  output logic                  T1_COMPARE_IRQ_OUT,
  output logic                  T0_FIRST_EDGE_OUT,
  output logic                  T0_SECOND_EDGE_OUT,
  output logic                  T1_FIRST_EDGE_OUT,
  output logic                  T1_SECOND_EDGE_OUT
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("tpe_top: CNT_W must lie in 2..32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers, index: t0 first, t0 second, t1 first, t1 second
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  assign pin_raw = {T1_SECOND_INPUT_PIN_IN, T1_FIRST_INPUT_PIN_IN,
                    T0_SECOND_INPUT_PIN_IN, T0_FIRST_INPUT_PIN_IN};

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] t0_cfg_reg;
  logic [7:0] t0_high_reg;
  logic [7:0] t1_cfg_reg;
  logic [7:0] t1_high_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // no hazard guard: rewriting while running is the caller's problem
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      t0_cfg_reg  <= tpe_pkg::CFG_RESET; // R1
      t0_high_reg <= tpe_pkg::HIGH_RESET; // R1
      t1_cfg_reg  <= tpe_pkg::CFG_RESET; // R1
      t1_high_reg <= tpe_pkg::HIGH_RESET; // R1
    end else if (REG_WR_IN) begin // R10
      case (REG_ADDR_IN)
        tpe_pkg::T0_CFG_ADDR:  t0_cfg_reg  <= REG_WDATA_IN & tpe_pkg::CFG_WMASK; // R17
        tpe_pkg::T0_HIGH_ADDR: t0_high_reg <= REG_WDATA_IN & tpe_pkg::HIGH_WMASK; // R17
        tpe_pkg::T1_CFG_ADDR:  t1_cfg_reg  <= REG_WDATA_IN & tpe_pkg::CFG_WMASK; // R17
        tpe_pkg::T1_HIGH_ADDR: t1_high_reg <= REG_WDATA_IN & tpe_pkg::HIGH_WMASK; // R17
        default: ;
      endcase
    end
  end

  always_comb begin
    case (REG_ADDR_IN)
      tpe_pkg::T0_CFG_ADDR:  rdata_next = t0_cfg_reg;
      tpe_pkg::T0_HIGH_ADDR: rdata_next = t0_high_reg;
      tpe_pkg::T1_CFG_ADDR:  rdata_next = t1_cfg_reg;
      tpe_pkg::T1_HIGH_ADDR: rdata_next = t1_high_reg;
      default:               rdata_next = tpe_pkg::RDATA_IDLE;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= tpe_pkg::RDATA_IDLE;
    end else if (REG_RD_IN) begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_OUT = rdata_reg;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [2:0] sel [2];
  logic [1:0] edge_mode [4];
  logic [1:0] run;
  logic [1:0] interval;

  assign sel[0] = {t0_high_reg[tpe_pkg::SEL_HIGH_BIT],
                   t0_cfg_reg[tpe_pkg::SEL_LOW_LSB +: 2]}; // R7
  assign sel[1] = {t1_high_reg[tpe_pkg::SEL_HIGH_BIT],
                   t1_cfg_reg[tpe_pkg::SEL_LOW_LSB +: 2]}; // R7

  assign edge_mode[0] = t0_cfg_reg[tpe_pkg::FIRST_EDGE_LSB +: 2]; // R3
  assign edge_mode[1] = t0_cfg_reg[tpe_pkg::SECOND_EDGE_LSB +: 2]; // R2
  assign edge_mode[2] = t1_cfg_reg[tpe_pkg::FIRST_EDGE_LSB +: 2]; // R6
  assign edge_mode[3] = t1_cfg_reg[tpe_pkg::SECOND_EDGE_LSB +: 2]; // R6

  assign run      = {T1_RUN_IN, T0_RUN_IN};
  assign interval = {T1_INTERVAL_IN, T0_INTERVAL_IN};

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [tpe_pkg::DIV_W-1:0] div_reg;
  logic tick2;
  logic tick4;
  logic tick16;
  logic tick32;
  logic tick64;
  logic tick128;
  logic tick256;

  // shared free-running divider: first tick after a start may come early
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign tick2   = &div_reg[tpe_pkg::DIV2_LOG-1:0];
  assign tick4   = &div_reg[tpe_pkg::DIV4_LOG-1:0];
  assign tick16  = &div_reg[tpe_pkg::DIV16_LOG-1:0];
  assign tick32  = &div_reg[tpe_pkg::DIV32_LOG-1:0];
  assign tick64  = &div_reg[tpe_pkg::DIV64_LOG-1:0];
  assign tick128 = &div_reg[tpe_pkg::DIV128_LOG-1:0];
  assign tick256 = &div_reg[tpe_pkg::DIV256_LOG-1:0];

  // ----------------------------------------------------------------
  // internal count clock per timer
  // ----------------------------------------------------------------
  logic [1:0] int_tick;
  logic [1:0] ext_sel;

  always_comb begin
    case (sel[0])
      tpe_pkg::SEL_0: int_tick[0] = tick2; // R4
      tpe_pkg::SEL_1: int_tick[0] = tick16; // R4
      tpe_pkg::SEL_2: int_tick[0] = WATCH_TIMER_IRQ_IN; // R4
      tpe_pkg::SEL_4: int_tick[0] = tick4; // R4
      tpe_pkg::SEL_5: int_tick[0] = tick64; // R4
      tpe_pkg::SEL_6: int_tick[0] = tick256; // R4
      default:        int_tick[0] = 1'b0;
    endcase
  end

  always_comb begin
    case (sel[1])
      tpe_pkg::SEL_0: int_tick[1] = tick2; // R5
      tpe_pkg::SEL_1: int_tick[1] = tick4; // R5
      tpe_pkg::SEL_2: int_tick[1] = tick16; // R5
      tpe_pkg::SEL_4: int_tick[1] = tick32; // R5
      tpe_pkg::SEL_5: int_tick[1] = tick128; // R5
      tpe_pkg::SEL_6: int_tick[1] = tick256; // R5
      default:        int_tick[1] = 1'b0;
    endcase
  end

  assign ext_sel[0] = (sel[0] == tpe_pkg::SEL_EXT);
  assign ext_sel[1] = (sel[1] == tpe_pkg::SEL_EXT);

  // ----------------------------------------------------------------
  // edge filters
  // ----------------------------------------------------------------
  // with a pin as count source, sampling falls back to fxx/2
  logic [1:0] sample_tick;
  logic [3:0] edge_pulse;

  assign sample_tick[0] = ext_sel[0] ? tick2 : int_tick[0]; // R8 R15
  assign sample_tick[1] = ext_sel[1] ? tick2 : int_tick[1]; // R8 R15

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      tpe_edge_filter u_edge (
        .clk_in    (CLK_SYS_IN),
        .rst_n_in  (rst_n),
        .sample_in (sample_tick[gi/2]), // R15
        .pin_in    (pin_sync_reg[gi]),
        .mode_in   (edge_mode[gi]),
        .run_in    (run[gi/2]),
        .edge_out  (edge_pulse[gi])
      );
    end
  endgenerate

  assign T0_FIRST_EDGE_OUT  = edge_pulse[0];
  assign T0_SECOND_EDGE_OUT = edge_pulse[1];
  assign T1_FIRST_EDGE_OUT  = edge_pulse[2];
  assign T1_SECOND_EDGE_OUT = edge_pulse[3];

  // ----------------------------------------------------------------
  // counters and interval compare
  // ----------------------------------------------------------------
  logic [1:0]       count_tick;
  logic [CNT_W-1:0] cnt_reg [2];
  logic [CNT_W-1:0] cnt_next [2];
  logic [CNT_W-1:0] cmp [2];
  logic [1:0]       match;
  logic [1:0]       irq_reg;

  assign cmp[0] = T0_COMPARE_IN;
  assign cmp[1] = T1_COMPARE_IN;

  // first-input edge as count clock: its clear or capture use is barred
  assign count_tick[0] = ext_sel[0] ? edge_pulse[0] : int_tick[0]; // R4 R9
  assign count_tick[1] = ext_sel[1] ? edge_pulse[2] : int_tick[1]; // R5 R9

  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      assign match[gi] = interval[gi] && (cnt_reg[gi] == cmp[gi]);

      always_comb begin
        if (!run[gi]) begin
          cnt_next[gi] = '0;
        end else if (count_tick[gi] && match[gi]) begin
          cnt_next[gi] = '0; // R13
        end else if (count_tick[gi]) begin
          cnt_next[gi] = cnt_reg[gi] + 1'b1; // R16
        end else begin
          cnt_next[gi] = cnt_reg[gi];
        end
      end

      always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
          cnt_reg[gi] <= '0;
        end else begin
          cnt_reg[gi] <= cnt_next[gi];
        end
      end

      // pulse lands with the clear
      always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
          irq_reg[gi] <= 1'b0;
        end else begin
          irq_reg[gi] <= run[gi] && count_tick[gi] && match[gi]; // R14
        end
      end
    end
  endgenerate

  assign T0_COUNT_OUT       = cnt_reg[0];
  assign T1_COUNT_OUT       = cnt_reg[1];
  assign T0_COMPARE_IRQ_OUT = irq_reg[0];
  assign T1_COMPARE_IRQ_OUT = irq_reg[1];

endmodule

`default_nettype wire

// ### inc/tpe_pkg.sv
`default_nettype none

package tpe_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] T0_CFG_ADDR  = 32'hFFFF_F206;
  localparam logic [31:0] T0_HIGH_ADDR = 32'hFFFF_F20E;
  localparam logic [31:0] T1_CFG_ADDR  = 32'hFFFF_F216;
  localparam logic [31:0] T1_HIGH_ADDR = 32'hFFFF_F21E;

  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] HIGH_RESET  = 8'h00;
  localparam logic [7:0] CFG_WMASK   = 8'hF3;
  localparam logic [7:0] HIGH_WMASK  = 8'h01;
  localparam logic [7:0] RDATA_IDLE  = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SECOND_EDGE_LSB = 6;
  localparam int FIRST_EDGE_LSB  = 4;
  localparam int SEL_LOW_LSB     = 0;
  localparam int SEL_HIGH_BIT    = 0;

  // ----------------------------------------------------------------
  // edge encoding, code 2 prohibited
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BAD  = 2'h2,
    EDGE_BOTH = 2'h3
  } tpe_edge_t;

  // ----------------------------------------------------------------
  // count clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_0      = 3'h0;
  localparam logic [2:0] SEL_1      = 3'h1;
  localparam logic [2:0] SEL_2      = 3'h2;
  localparam logic [2:0] SEL_EXT    = 3'h3;
  localparam logic [2:0] SEL_4      = 3'h4;
  localparam logic [2:0] SEL_5      = 3'h5;
  localparam logic [2:0] SEL_6      = 3'h6;
  localparam logic [2:0] SEL_BAD    = 3'h7;

  // divide ratios as log2 of the fxx divisor
  localparam int DIV2_LOG   = 1;
  localparam int DIV4_LOG   = 2;
  localparam int DIV16_LOG  = 4;
  localparam int DIV32_LOG  = 5;
  localparam int DIV64_LOG  = 6;
  localparam int DIV128_LOG = 7;
  localparam int DIV256_LOG = 8;
  localparam int DIV_W      = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 8;
  localparam int EXT_MIN_PULSE_NS = 2 * (1 << DIV2_LOG) * CLK_PERIOD_NS;
  localparam int EXT_MIN_PULSE_CYC = EXT_MIN_PULSE_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// ### tb/tb_timer_prescaler_edge_interval.sv
`default_nettype none

// ----------------------------------------
// prescaler, edge and interval bench
// ----------------------------------------
module tb_timer_prescaler_edge_interval;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst, reg_wr, reg_rd, watch, load, go;
  logic        t0_run, t1_run, t0_int, t1_int;
  logic [31:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, width;
  logic [15:0] t0_cmp, t1_cmp, t0_cnt, t1_cnt;
  logic [3:0]  pins, init, edges;
  logic [1:0]  irq, pin_sel;
  logic [2:0]  wcnt = 3'h0;
  int          n_mismatch = 0;
  int          checks = 0;
  int          ecnt[4] = '{0, 0, 0, 0};
  logic [31:0] adr[4] = '{tpe_pkg::T0_CFG_ADDR, tpe_pkg::T0_HIGH_ADDR,
                          tpe_pkg::T1_CFG_ADDR, tpe_pkg::T1_HIGH_ADDR};
  int          per[2][8] = '{'{4, 32, 16, 0, 8, 128, 512, 0}, '{4, 8, 32, 0, 64, 256, 512, 0}};
  int          nedge[4] = '{2, 2, 0, 4};

  tpe_top dut_u (
    .CLK_SYS_IN(clk_sys), .NRST_IN(nrst), .REG_ADDR_IN(reg_addr), .REG_WR_IN(reg_wr),
    .REG_RD_IN(reg_rd), .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(reg_rdata),
    .T0_RUN_IN(t0_run), .T1_RUN_IN(t1_run), .T0_INTERVAL_IN(t0_int),
    .T1_INTERVAL_IN(t1_int), .T0_COMPARE_IN(t0_cmp), .T1_COMPARE_IN(t1_cmp),
    .WATCH_TIMER_IRQ_IN(watch), .T0_FIRST_INPUT_PIN_IN(pins[0]),
    .T0_SECOND_INPUT_PIN_IN(pins[1]), .T1_FIRST_INPUT_PIN_IN(pins[2]),
    .T1_SECOND_INPUT_PIN_IN(pins[3]), .T0_COUNT_OUT(t0_cnt), .T1_COUNT_OUT(t1_cnt),
    .T0_COMPARE_IRQ_OUT(irq[0]), .T1_COMPARE_IRQ_OUT(irq[1]),
    .T0_FIRST_EDGE_OUT(edges[0]), .T0_SECOND_EDGE_OUT(edges[1]),
    .T1_FIRST_EDGE_OUT(edges[2]), .T1_SECOND_EDGE_OUT(edges[3]));

  tpe_pin_model pin_u (
    .clk_in(clk_sys), .load_in(load), .init_in(init), .go_in(go), .pin_in(pin_sel),
    .width_in(width), .pins_out(pins));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // watch tick every 8 cycles
  always @(posedge clk_sys) begin
    wcnt  <= wcnt + 3'h1;
    watch <= &wcnt;
    for (int i = 0; i < 4; i++) begin
      if (edges[i] === 1'b1) begin
        ecnt[i] <= ecnt[i] + 1;
      end
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_reg(input logic [31:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic pulse(input logic [1:0] p, input logic [7:0] w);
    pin_sel <= p;
    width   <= w;
    go      <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    clocks(int'(w) + 8);
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    logic [7:0] d;
    int         e, n, got;
    {nrst, reg_wr, reg_rd, go, t0_run, t1_run, t0_int, t1_int} = '0;
    {reg_addr, reg_wdata, t0_cmp, t1_cmp, pin_sel} = '0;
    width = 8'h06;
    load  = 1'b1;
    init  = 4'h1;
    clocks(20);
    nrst <= 1'b1;
    clocks(3);
    load <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(adr[i], d);
      check(d, 8'h00);
      wr_reg(adr[i], 8'hFF);
      rd_reg(adr[i], d);
      check(d, i[0] ? 8'h01 : 8'hF3);
    end
    wr_reg(32'hFFFF_F207, 8'hFF);
    rd_reg(32'hFFFF_F207, d);
    check(d, 8'h00);
    for (int i = 0; i < 4; i++) wr_reg(adr[i], 8'h00);
    // first run after reset with the pin already high
    wr_reg(adr[0], 8'h10);
    e = ecnt[0];
    t0_run <= 1'b1;
    clocks(12);
    check(ecnt[0] - e, 1);
    t0_run <= 1'b0;
    clocks(10);
    e = ecnt[0];
    t0_run <= 1'b1;
    clocks(20);
    check(ecnt[0] - e, 0);
    // two low cycles: exactly one fxx/2 sample sees the glitch
    pulse(2'd0, 8'h02);
    check(ecnt[0] - e, 0);
    t0_run <= 1'b0;
    init   <= 4'h0;
    load   <= 1'b1;
    clocks(1);
    load <= 1'b0;
    clocks(10);
    // edge modes on every pin, first input also as count clock
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(adr[p & 2], 8'(m * 8'h50 + 3));
        t0_run <= 1'b1;
        t1_run <= 1'b1;
        clocks(10);
        e = ecnt[p];
        pulse(2'(p), 8'(tpe_pkg::EXT_MIN_PULSE_CYC + 2));
        pulse(2'(p), 8'(tpe_pkg::EXT_MIN_PULSE_CYC + 2));
        clocks(12);
        check(ecnt[p] - e, nedge[m]);
        check(p < 2 ? t0_cnt : t1_cnt, p[0] ? 0 : nedge[m]);
        t0_run <= 1'b0;
        t1_run <= 1'b0;
        clocks(2);
        wr_reg(adr[p & 2], 8'h00);
      end
    end
    // interval period for every count clock code except the edge code 3, compare value 1
    t0_cmp <= 16'h0001;
    t1_cmp <= 16'h0001;
    t0_int <= 1'b1;
    t1_int <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 8; c++) begin
        if (c == 3) continue;
        wr_reg(adr[2 * t], 8'(c & 3));
        wr_reg(adr[2 * t + 1], 8'(c >> 2));
        if (t == 0) t0_run <= 1'b1;
        else t1_run <= 1'b1;
        n = 0;
        while (irq[t] !== 1'b1 && n < 1100) begin
          @(posedge clk_sys);
          n++;
        end
        got = 0;
        if (n < 1100) begin
          do begin
            @(posedge clk_sys);
            got++;
          end while (irq[t] !== 1'b1 && got < 1100);
        end
        check(got, per[t][c]);
        t0_run <= 1'b0;
        t1_run <= 1'b0;
        clocks(2);
      end
    end
    end_of_test;
  end
endmodule

`default_nettype wire

// ### tb/tpe_pin_model.sv
`default_nettype none

// ----------------------------------------
// external timer input pins
// ----------------------------------------
module tpe_pin_model (
  input  wire logic       clk_in,
  input  wire logic       load_in,
  input  wire logic [3:0] init_in,
  input  wire logic       go_in,
  input  wire logic [1:0] pin_in,
  input  wire logic [7:0] width_in,
  output logic      [3:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg;

  // pin inverts for width_in cycles; widths under the minimum only on request
  always_ff @(posedge clk_in) begin
    if (load_in) begin
      pins_out <= init_in;
      left_reg <= 8'h00;
    end else if (go_in) begin
      pins_out[pin_in] <= ~pins_out[pin_in];
      left_reg         <= width_in;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
      if (left_reg == 8'h01) begin
        pins_out[pin_in] <= ~pins_out[pin_in];
      end
    end
  end
endmodule

`default_nettype wire

// ### tb/tpe_top_monitor.sv
`default_nettype none

// ----------------------------------------
// port checker for the prescaler block
// ----------------------------------------
module tpe_top_monitor #(
  parameter int CNT_W = 16
) (
  input wire logic             CLK_SYS_IN,
  input wire logic             NRST_IN,
  input wire logic [31:0]      REG_ADDR_IN,
  input wire logic             REG_WR_IN,
  input wire logic             REG_RD_IN,
  input wire logic [7:0]       REG_WDATA_IN,
  input wire logic [7:0]       REG_RDATA_OUT,
  input wire logic             T0_RUN_IN,
  input wire logic             T0_INTERVAL_IN,
  input wire logic [CNT_W-1:0] T0_COMPARE_IN,
  input wire logic [CNT_W-1:0] T0_COUNT_OUT,
  input wire logic [CNT_W-1:0] T1_COUNT_OUT,
  input wire logic             T0_COMPARE_IRQ_OUT,
  input wire logic             T1_COMPARE_IRQ_OUT,
  input wire logic             T0_FIRST_EDGE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mapped;
  assign mapped = REG_ADDR_IN inside {tpe_pkg::T0_CFG_ADDR, tpe_pkg::T0_HIGH_ADDR,
                                      tpe_pkg::T1_CFG_ADDR, tpe_pkg::T1_HIGH_ADDR};

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!NRST_IN);

  sequence s_high_wr;
    REG_WR_IN && REG_ADDR_IN == tpe_pkg::T0_HIGH_ADDR;
  endsequence
  sequence s_high_rd;
    REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == tpe_pkg::T0_HIGH_ADDR;
  endsequence

  irq_clear_t0_a : assert property (
    T0_COMPARE_IRQ_OUT |-> T0_COUNT_OUT == '0) else $error("t0 irq without clear");
  irq_clear_t1_a : assert property (
    T1_COMPARE_IRQ_OUT |-> T1_COUNT_OUT == '0) else $error("t1 irq without clear");
  irq_cause_a : assert property (
    T0_COMPARE_IRQ_OUT |-> $past(T0_INTERVAL_IN) && $past(T0_COUNT_OUT) == $past(T0_COMPARE_IN))
    else $error("t0 irq without match");
  count_step_t0_a : assert property (
    $changed(T0_COUNT_OUT) |-> T0_COUNT_OUT == '0 || T0_COUNT_OUT == $past(T0_COUNT_OUT) + 1'b1)
    else $error("t0 count jumped");
  count_step_t1_a : assert property (
    $changed(T1_COUNT_OUT) |-> T1_COUNT_OUT == '0 || T1_COUNT_OUT == $past(T1_COUNT_OUT) + 1'b1)
    else $error("t1 count jumped");
  stop_clear_a : assert property (
    !T0_RUN_IN |=> T0_COUNT_OUT == '0) else $error("t0 count kept while stopped");
  edge_run_a : assert property (
    T0_FIRST_EDGE_OUT |-> $past(T0_RUN_IN)) else $error("edge while stopped");
  edge_pulse_a : assert property (
    T0_FIRST_EDGE_OUT |=> !T0_FIRST_EDGE_OUT) else $error("edge pulse too long");
  unmapped_rd_a : assert property (
    REG_RD_IN && !mapped |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
  high_rw_a : assert property (
    s_high_wr ##2 s_high_rd |=> REG_RDATA_OUT == ($past(REG_WDATA_IN, 3) & 8'h01))
    else $error("high bit readback wrong");
endmodule

bind tpe_top tpe_top_monitor #(.CNT_W(CNT_W)) mon_u (
  .CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .T0_RUN_IN(T0_RUN_IN), .T0_INTERVAL_IN(T0_INTERVAL_IN),
  .T0_COMPARE_IN(T0_COMPARE_IN), .T0_COUNT_OUT(T0_COUNT_OUT), .T1_COUNT_OUT(T1_COUNT_OUT),
  .T0_COMPARE_IRQ_OUT(T0_COMPARE_IRQ_OUT), .T1_COMPARE_IRQ_OUT(T1_COMPARE_IRQ_OUT),
  .T0_FIRST_EDGE_OUT(T0_FIRST_EDGE_OUT));

`default_nettype wire
